// file: common/vhcr_defs.svh
// Offsets, field positions and reset values of the host control registers
`ifndef VHCR_DEFS_SVH
`define VHCR_DEFS_SVH

// ----------------------------------------------------------------------
// Configuration space offsets
// ----------------------------------------------------------------------
`define VHCR_CFG_MEM_BASE   8'h10
`define VHCR_CFG_ROM_BASE   8'h30

// ----------------------------------------------------------------------
// I/O port addresses
// ----------------------------------------------------------------------
`define VHCR_IO_SETUP       16'h46E8
`define VHCR_IO_GLOBAL_SLEEP_ENABLE        16'h0102
`define VHCR_IO_BOARD_SLEEP_OVERRIDE        16'h0106
`define VHCR_IO_STAT1_MONO  16'h03BA
`define VHCR_IO_STAT1_COLOR 16'h03DA
`define VHCR_IO_FCR_RD      16'h03CA
`define VHCR_IO_MSR_WR      16'h03C2
`define VHCR_IO_MSR_RD      16'h03CC
`define VHCR_IO_SEQ_INDEX   16'h03C4
`define VHCR_IO_SEQ_DATA    16'h03C5

// ----------------------------------------------------------------------
// Field positions and sequencer register indices
// ----------------------------------------------------------------------
`define VHCR_PCI_MEMORY_WINDOW_BASE_LSB      22
`define VHCR_PCI_ROM_WINDOW_BASE_LSB      18
`define VHCR_SETUP_VGA_EN   3
`define VHCR_SETUP_MODE     4
`define VHCR_SEQ_IDX_RESET  3'h0
`define VHCR_SEQ_IDX_CLOCK  3'h1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VHCR_RST_BYTE       8'h00
`define VHCR_RST_SEQ_RESET  2'h3
`define VHCR_RST_SEQ_CLOCK  5'h00

// ----------------------------------------------------------------------
// Timing counts, last dot count of one character
// ----------------------------------------------------------------------
`define VHCR_DOTS_8_LAST    4'h7
`define VHCR_DOTS_9_LAST    4'h8

`endif

// file: common/vhcr_pkg.sv
// Types shared by the host control register bank
package vhcr_pkg;

	// I/O port access from the host
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} vhcr_io_req_s;

	// Configuration cycle from the host
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} vhcr_cfg_req_s;

	// Memory cycle address presented for decoding
	typedef struct packed {
		logic        valid;
		logic        legacy;
		logic [31:0] addr;
	} vhcr_mem_req_s;

	// Shift register load cadence
	typedef enum logic [1:0] {
		VHCR_LOAD_EVERY,
		VHCR_LOAD_OTHER,
		VHCR_LOAD_FOURTH
	} vhcr_load_e;

endpackage

// file: logic/vhcr_regs.sv
// Host control and status register bank of the display controller
`timescale 1ns/1ns
`include "vhcr_defs.svh"

module vhcr_regs
	import vhcr_pkg::*;
(
	input  wire logic          core_clk,        // Bus clock, 125 MHz
	input  wire logic          nrst,            // Asynchronous reset
	input  wire vhcr_cfg_req_s cfgReq,          // Configuration cycle
	output logic [31:0]        cfgRdata_q,      // Configuration read data
	input  wire vhcr_io_req_s  ioReq,           // I/O port cycle
	output logic [7:0]         ioRdata_q,       // I/O read data
	output logic               ioAck_q,         // I/O cycle claimed
	input  wire vhcr_mem_req_s memReq,          // Memory cycle to decode
	input  wire logic          pciMemEnable,    // Device control memory enable
	output logic               memHitVideo_q,   // Window lower half hit
	output logic               memHitCtrl_q,    // Window upper half hit
	output logic               memHitRom_q,     // ROM window hit
	output logic               legacyGrant_q,   // Legacy memory access allowed
	input  wire logic          vlBusPin,        // High on the VL-Bus
	input  wire logic          boardStrapPin,   // Board disable strap
	input  wire logic          crtIrq,          // CRT interrupt pending
	input  wire logic          hDispEn,         // Horizontal display enable
	input  wire logic          vDispEn,         // Vertical display enable
	input  wire logic          vsyncRaw,        // Vertical sync, active high
	input  wire logic          hsyncRaw,        // Horizontal sync, active high
	input  wire logic          emulationModeBit, // Retrace status variant
	input  wire logic          senseIn,         // Monitor sense level
	input  wire logic [1:0]    videoFeedback,   // Diagnostic video bits
	input  wire logic          dotTick,         // One pulse per dot clock
	output logic               vgaEnable_q,     // Setup port enable
	output logic               vgaAwake_q,      // Sleep control result
	output logic               ioColor_q,       // Color port decode
	output logic [1:0]         dotClkSel_q,     // Dot clock source
	output logic               pageLow_q,       // Lower page selected
	output logic               hsyncPin_q,      // Horizontal sync pin
	output logic               vsyncPin_q,      // Vertical sync pin
	output logic               seqAsyncRstN_q,  // Sequencer async reset
	output logic               seqSyncRstN_q,   // Sequencer sync reset
	output logic               charTick_q,      // Character clock pulse
	output logic               shiftLoad_q,     // Video shift load pulse
	output logic               pixClkEn_q       // Pixel clock enable
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [31:22] pci_memory_window_base_q;
	logic [31:18] pci_rom_window_base_q;
	logic         romEn_q;
	logic [1:0]   setup_q;
	logic         global_sleep_enable_q;
	logic [1:0]   board_sleep_override_q;
	logic [3:0]   fcr_q;
	logic [7:0]   msr_q;
	logic [2:0]   seqIdx_q;
	logic [1:0]   seqRst_q;
	logic [4:0]   seqClk_q;
	logic [1:0]   vlSync_q;
	logic [1:0]   strapSync_q;
	logic [3:0]   dotCnt_q;
	logic [1:0]   loadCnt_q;
	logic         pixPhase_q;
	logic         setupMode;
	logic         vlBus;
	logic         strap;
	logic         vsyncMix;
	vhcr_load_e   loadMode;

	assign setupMode = setup_q[1];
	assign vlBus     = vlSync_q[1];
	assign strap     = strapSync_q[1];

	// Address compare on an I/O cycle
	function automatic logic ioAt(input logic [15:0] a,
		input logic [15:0] p);
		ioAt = (a == p);
	endfunction

	// Status one and feature writes follow the mono/color choice
	function automatic logic [15:0] stat1Addr(input logic color);
		stat1Addr = color ? `VHCR_IO_STAT1_COLOR : `VHCR_IO_STAT1_MONO;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vlSync_q    <= 2'h0;
			strapSync_q <= 2'h0;
		end else begin
			vlSync_q    <= {vlSync_q[0], vlBusPin};
			strapSync_q <= {strapSync_q[0], boardStrapPin};
		end
	end

	// ------------------------------------------------------------------
	// Configuration space registers
	// ------------------------------------------------------------------
	// Byte-lane writes to the two window bases
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pci_memory_window_base_q <= 10'h000;
			pci_rom_window_base_q <= 14'h0000;
			romEn_q <= 1'b0;
		end else if (cfgReq.wr) begin
			if (cfgReq.addr == `VHCR_CFG_MEM_BASE) begin
				for (int i = 22; i < 32; i++) begin
					if (cfgReq.be[i/8])
						pci_memory_window_base_q[i] <= cfgReq.wdata[i];
				end
			end else if (cfgReq.addr == `VHCR_CFG_ROM_BASE) begin
				for (int i = 18; i < 32; i++) begin
					if (cfgReq.be[i/8])
						pci_rom_window_base_q[i] <= cfgReq.wdata[i];
				end
				if (cfgReq.be[0])
					romEn_q <= cfgReq.wdata[0];
			end
		end
	end

	// Configuration read data, low fields hard zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfgRdata_q <= 32'h0000_0000;
		end else if (cfgReq.rd) begin
			if (cfgReq.addr == `VHCR_CFG_MEM_BASE)
				cfgRdata_q <= {pci_memory_window_base_q, 22'h000000};
			else if (cfgReq.addr == `VHCR_CFG_ROM_BASE)
				cfgRdata_q <= {pci_rom_window_base_q, 17'h00000, romEn_q};
			else
				cfgRdata_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// Memory window decoding
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			memHitVideo_q <= 1'b0;
			memHitCtrl_q  <= 1'b0;
			memHitRom_q   <= 1'b0;
			legacyGrant_q <= 1'b0;
		end else begin
			memHitVideo_q <= memReq.valid && !memReq.legacy && pciMemEnable
				&& memReq.addr[31:22] == pci_memory_window_base_q
				&& !memReq.addr[21];
			memHitCtrl_q  <= memReq.valid && !memReq.legacy && pciMemEnable
				&& memReq.addr[31:22] == pci_memory_window_base_q
				&& memReq.addr[21];
			memHitRom_q   <= memReq.valid && !memReq.legacy && pciMemEnable
				&& romEn_q && memReq.addr[31:18] == pci_rom_window_base_q;
			legacyGrant_q <= memReq.valid && memReq.legacy
				&& msr_q[1] && vgaAwake_q;
		end
	end

	// ------------------------------------------------------------------
	// Setup and sleep registers
	// ------------------------------------------------------------------
	// Setup port is write only and exists only on the VL-Bus
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			setup_q <= 2'h0;
		end else if (ioReq.wr && vlBus && ioAt(ioReq.addr, `VHCR_IO_SETUP)) begin
			setup_q <= {ioReq.wdata[`VHCR_SETUP_MODE],
				ioReq.wdata[`VHCR_SETUP_VGA_EN]};
		end
	end

	// Sleep registers reachable only in setup mode
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			global_sleep_enable_q <= 1'b0;
			board_sleep_override_q <= 2'h0;
		end else if (ioReq.wr && setupMode) begin
			if (ioAt(ioReq.addr, `VHCR_IO_GLOBAL_SLEEP_ENABLE))
				global_sleep_enable_q <= ioReq.wdata[0];
			else if (ioAt(ioReq.addr, `VHCR_IO_BOARD_SLEEP_OVERRIDE) && strap)
				board_sleep_override_q <= ioReq.wdata[1:0];
		end
	end

	// Enable and sleep outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vgaEnable_q <= 1'b0;
			vgaAwake_q  <= 1'b0;
		end else begin
			vgaEnable_q <= setup_q[0];
			vgaAwake_q  <= board_sleep_override_q[1] ? board_sleep_override_q[0] : global_sleep_enable_q;
		end
	end

	// ------------------------------------------------------------------
	// General control registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fcr_q <= 4'h0;
			msr_q <= `VHCR_RST_BYTE;
		end else if (ioReq.wr) begin
			if (ioAt(ioReq.addr, stat1Addr(msr_q[0])))
				fcr_q <= {ioReq.wdata[3], 1'b0, ioReq.wdata[1:0]};
			else if (ioAt(ioReq.addr, `VHCR_IO_MSR_WR))
				msr_q <= {ioReq.wdata[7:5], 1'b0, ioReq.wdata[3:0]};
		end
	end

	// Sync mixing and polarity
	assign vsyncMix = fcr_q[3] ? (vsyncRaw | vDispEn) : vsyncRaw;

	// Display-side control outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ioColor_q   <= 1'b0;
			dotClkSel_q <= 2'h0;
			pageLow_q   <= 1'b0;
			hsyncPin_q  <= 1'b0;
			vsyncPin_q  <= 1'b0;
		end else begin
			ioColor_q   <= msr_q[0];
			dotClkSel_q <= msr_q[3:2];
			pageLow_q   <= msr_q[5];
			hsyncPin_q  <= hsyncRaw ^ msr_q[6];
			vsyncPin_q  <= vsyncMix ^ msr_q[7];
		end
	end

	// ------------------------------------------------------------------
	// Sequencer registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			seqIdx_q <= 3'h0;
			seqRst_q <= `VHCR_RST_SEQ_RESET;
			seqClk_q <= `VHCR_RST_SEQ_CLOCK;
		end else if (ioReq.wr) begin
			if (ioAt(ioReq.addr, `VHCR_IO_SEQ_INDEX)) begin
				seqIdx_q <= ioReq.wdata[2:0];
			end else if (ioAt(ioReq.addr, `VHCR_IO_SEQ_DATA)) begin
				if (seqIdx_q == `VHCR_SEQ_IDX_RESET)
					seqRst_q <= ioReq.wdata[1:0];
				else if (seqIdx_q == `VHCR_SEQ_IDX_CLOCK)
					seqClk_q <= {ioReq.wdata[4:2], 1'b0, ioReq.wdata[0]};
			end
		end
	end

	// Sequencer reset outputs, low forces the reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			seqAsyncRstN_q <= 1'b1;
			seqSyncRstN_q  <= 1'b1;
		end else begin
			seqAsyncRstN_q <= seqRst_q[0];
			seqSyncRstN_q  <= seqRst_q[1];
		end
	end

	// ------------------------------------------------------------------
	// I/O read path
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ioRdata_q <= 8'h00;
			ioAck_q   <= 1'b0;
		end else begin
			ioRdata_q <= 8'h00;
			ioAck_q   <= ioReq.rd || ioReq.wr;
			if (ioReq.rd) begin
				if (ioAt(ioReq.addr, `VHCR_IO_MSR_WR))
					ioRdata_q <= {crtIrq, 2'h0, senseIn, 4'h0};
				else if (ioAt(ioReq.addr, stat1Addr(msr_q[0])))
					ioRdata_q <= {2'h0, videoFeedback,
						emulationModeBit ? vsyncMix : vsyncRaw, 2'h0,
						hDispEn & vDispEn};
				else if (ioAt(ioReq.addr, `VHCR_IO_FCR_RD))
					ioRdata_q <= {4'h0, fcr_q};
				else if (ioAt(ioReq.addr, `VHCR_IO_MSR_RD))
					ioRdata_q <= msr_q;
				else if (ioAt(ioReq.addr, `VHCR_IO_SEQ_INDEX))
					ioRdata_q <= {5'h00, seqIdx_q};
				else if (ioAt(ioReq.addr, `VHCR_IO_SEQ_DATA)
					&& seqIdx_q == `VHCR_SEQ_IDX_RESET)
					ioRdata_q <= {6'h00, seqRst_q};
				else if (ioAt(ioReq.addr, `VHCR_IO_SEQ_DATA)
					&& seqIdx_q == `VHCR_SEQ_IDX_CLOCK)
					ioRdata_q <= {3'h0, seqClk_q};
				else if (setupMode && ioAt(ioReq.addr, `VHCR_IO_GLOBAL_SLEEP_ENABLE))
					ioRdata_q <= {7'h00, global_sleep_enable_q};
				else if (setupMode && strap
					&& ioAt(ioReq.addr, `VHCR_IO_BOARD_SLEEP_OVERRIDE))
					ioRdata_q <= {6'h00, board_sleep_override_q};
			end
		end
	end

	// ------------------------------------------------------------------
	// Character clock, shift load and pixel clock
	// ------------------------------------------------------------------
	// Dot counter wraps after eight or nine dots
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dotCnt_q   <= 4'h0;
			charTick_q <= 1'b0;
		end else begin
			charTick_q <= 1'b0;
			if (dotTick) begin
				if (dotCnt_q >= (seqClk_q[0] ? `VHCR_DOTS_8_LAST
					: `VHCR_DOTS_9_LAST)) begin
					dotCnt_q   <= 4'h0;
					charTick_q <= 1'b1;
				end else begin
					dotCnt_q <= dotCnt_q + 4'h1;
				end
			end
		end
	end

	always_comb begin
		if (seqClk_q[4])
			loadMode = VHCR_LOAD_FOURTH;
		else if (seqClk_q[2])
			loadMode = VHCR_LOAD_OTHER;
		else
			loadMode = VHCR_LOAD_EVERY;
	end

	// Load pulse on the chosen character clocks
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			loadCnt_q   <= 2'h0;
			shiftLoad_q <= 1'b0;
		end else begin
			shiftLoad_q <= 1'b0;
			if (charTick_q) begin
				loadCnt_q <= loadCnt_q + 2'h1;
				case (loadMode)
				VHCR_LOAD_FOURTH: shiftLoad_q <= (loadCnt_q == 2'h3);
				VHCR_LOAD_OTHER:  shiftLoad_q <= loadCnt_q[0];
				default:          shiftLoad_q <= 1'b1;
				endcase
			end
		end
	end

	// Pixel clock enable, every cycle or every second one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pixPhase_q <= 1'b0;
			pixClkEn_q <= 1'b0;
		end else begin
			pixPhase_q <= ~pixPhase_q;
			pixClkEn_q <= seqClk_q[3] ? pixPhase_q : 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_pci_memory_window_base_low_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		cfgReq.rd && cfgReq.addr == `VHCR_CFG_MEM_BASE
		|=> cfgRdata_q[21:0] == 22'h000000)
		else $error("memory base low bits not zero");

	a_pci_memory_window_base_write_full: assert property (@(posedge core_clk) disable iff (!nrst)
		cfgReq.wr && cfgReq.addr == `VHCR_CFG_MEM_BASE && cfgReq.be == 4'hF
		|=> pci_memory_window_base_q == $past(cfgReq.wdata[31:22]))
		else $error("memory base write lost");

	a_rom_gated: assert property (@(posedge core_clk) disable iff (!nrst)
		memHitRom_q |-> $past(romEn_q) && $past(pciMemEnable))
		else $error("rom hit while disabled");

	a_rom_low_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		cfgReq.rd && cfgReq.addr == `VHCR_CFG_ROM_BASE
		|=> cfgRdata_q[17:1] == 17'h00000)
		else $error("rom base low bits not zero");

	a_global_sleep_enable_setup_only: assert property (@(posedge core_clk) disable iff (!nrst)
		ioReq.wr && ioReq.addr == `VHCR_IO_GLOBAL_SLEEP_ENABLE && !setupMode
		|=> $stable(global_sleep_enable_q))
		else $error("enable written outside setup");

	a_board_sleep_override_strap_only: assert property (@(posedge core_clk) disable iff (!nrst)
		ioReq.wr && ioReq.addr == `VHCR_IO_BOARD_SLEEP_OVERRIDE && !(setupMode && strap)
		|=> $stable(board_sleep_override_q))
		else $error("override written while locked");

	a_vsync_pin_mix: assert property (@(posedge core_clk) disable iff (!nrst)
		vsyncPin_q == $past((fcr_q[3] ? (vsyncRaw | vDispEn) : vsyncRaw)
			^ msr_q[7]))
		else $error("vertical sync pin wrong");

	a_seq_idx_read: assert property (@(posedge core_clk) disable iff (!nrst)
		ioReq.rd && ioReq.addr == `VHCR_IO_SEQ_INDEX
		|=> ioRdata_q == {5'h00, $past(seqIdx_q)})
		else $error("sequencer index read wrong");

	a_load_fourth_gap: assert property (@(posedge core_clk) disable iff (!nrst)
		shiftLoad_q && seqClk_q[4] && $stable(seqClk_q)
		|=> !shiftLoad_q [*8])
		else $error("shift load too early");

	a_pix_half_rate: assert property (@(posedge core_clk) disable iff (!nrst)
		seqClk_q[3] && $past(seqClk_q[3]) && pixClkEn_q
		|=> !pixClkEn_q)
		else $error("pixel enable not halved");

endmodule

// file: test/vhcr_host.sv
// Host processor model issuing configuration and I/O cycles
`timescale 1ns/1ns
module vhcr_host
	import vhcr_pkg::*;
(
	input  wire logic [31:0] cfgRdata_q, // Config read data
	input  wire logic [7:0]  ioRdata_q,  // I/O read data
	input  wire logic        ioAck_q,    // I/O claim pulse
	input  wire logic        core_clk,   // Bus clock
	output vhcr_cfg_req_s    cfgReq,     // Config cycle
	output vhcr_io_req_s     ioReq       // I/O cycle
);
	// Buses idle at time zero
	initial begin
		cfgReq = '0;
		ioReq = '0;
	end

	// One config cycle; strobe seen at one edge, answer read 1 ns after that edge
	task automatic cfg(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		if (w && a == 8'h10 && d[31:22] == 10'h0) d[31:22] = 10'h1;
		if (w && a == 8'h30 && d[31:18] == 14'h0) d[31:18] = 14'h1;
		@(posedge core_clk);
		cfgReq <= '{rd: !w, wr: w, addr: a, be: 4'hF, wdata: d};
		@(posedge core_clk);
		cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
		#1 q = cfgRdata_q;
	endtask

	// One I/O cycle; released lines show inverted values
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic k);
		@(posedge core_clk);
		ioReq <= '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge core_clk);
		ioReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		#1 q = ioRdata_q;
		k = ioAck_q;
	endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the host control register bank
`timescale 1ns/1ns
module tb
	import vhcr_pkg::*;
;
	logic          core_clk, nrst, pciMemEnable, vlBusPin, boardStrapPin;
	logic          crtIrq, hDispEn, vDispEn, vsyncRaw, hsyncRaw;
	logic          emulationModeBit, senseIn, dotTick;
	logic [1:0]    videoFeedback, dotClkSel_q;
	vhcr_cfg_req_s cfgReq;
	vhcr_io_req_s  ioReq;
	vhcr_mem_req_s memReq;
	logic [31:0]   cfgRdata_q;
	logic [7:0]    ioRdata_q;
	logic          ioAck_q, memHitVideo_q, memHitCtrl_q, memHitRom_q;
	logic          legacyGrant_q, vgaEnable_q, vgaAwake_q, ioColor_q;
	logic          pageLow_q, hsyncPin_q, vsyncPin_q, seqAsyncRstN_q;
	logic          seqSyncRstN_q, charTick_q, shiftLoad_q, pixClkEn_q;
	int            err_total, check_count;

	vhcr_regs i_dut (.core_clk, .nrst, .cfgReq, .cfgRdata_q, .ioReq,
		.ioRdata_q, .ioAck_q, .memReq, .pciMemEnable, .memHitVideo_q,
		.memHitCtrl_q, .memHitRom_q, .legacyGrant_q, .vlBusPin,
		.boardStrapPin, .crtIrq, .hDispEn, .vDispEn, .vsyncRaw, .hsyncRaw,
		.emulationModeBit, .senseIn, .videoFeedback, .dotTick, .vgaEnable_q,
		.vgaAwake_q, .ioColor_q, .dotClkSel_q, .pageLow_q, .hsyncPin_q,
		.vsyncPin_q, .seqAsyncRstN_q, .seqSyncRstN_q, .charTick_q,
		.shiftLoad_q, .pixClkEn_q);
	vhcr_host i_host (.cfgRdata_q, .ioRdata_q, .ioAck_q, .core_clk,
		.cfgReq, .ioReq);

	// Bus clock, 8 ns period
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic iow(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		i_host.io(1'b1, a, d, q, k);
		chk($sformatf("ioAck %h", a), 1, k);
	endtask
	task automatic ior(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic       k;
		i_host.io(1'b0, a, 8'h00, q, k);
		chk($sformatf("io %h", a), e, q);
	endtask
	task automatic cfgw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_host.cfg(1'b1, a, d, q);
	endtask
	task automatic cfgr(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		i_host.cfg(1'b0, a, 32'h0, q);
		chk($sformatf("cfg %h", a), e, q);
	endtask
	// One memory cycle, hits judged 1 ns after the edge that takes it
	task automatic mem(input logic [31:0] a, input logic [2:0] e);
		@(posedge core_clk);
		memReq <= '{valid: 1'b1, legacy: 1'b0, addr: a};
		@(posedge core_clk);
		memReq <= '{valid: 1'b0, legacy: 1'b0, addr: ~a};
		#1 chk("hits", e, {memHitVideo_q, memHitCtrl_q, memHitRom_q});
	endtask
	// Cycles between two pulses of the character or load strobe
	task automatic gap(input logic ld, output int n);
		int k;
		for (k = 0; k < 99 && (ld ? shiftLoad_q : charTick_q) !== 1'b1; k++)
			cyc(1);
		if ((ld ? shiftLoad_q : charTick_q) !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		n = 0;
		do begin
			cyc(1);
			n++;
		end while ((ld ? shiftLoad_q : charTick_q) !== 1'b1 && n < 99);
		if (n >= 99) begin
			err_total++;
			report_and_stop();
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		chk("asyncRstN", 1, seqAsyncRstN_q);
		chk("vgaEnable", 0, vgaEnable_q);
		ior(16'h03CC, 8'h00);
		ior(16'h03CA, 8'h00);
		ior(16'h03C4, 8'h00);
		cfgr(8'h30, 32'h0);
		iow(16'h0300, 8'h55);
		ior(16'h0300, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_cfg;
		cfgw(8'h10, 32'hFFFFFFFF);
		cfgr(8'h10, 32'hFFC00000);
		cfgw(8'h30, 32'hFFFFFFFF);
		cfgr(8'h30, 32'hFFFC0001);
		cfgw(8'h10, 32'h00400000);
		cfgw(8'h30, 32'h00040000);
		@(posedge core_clk);
		pciMemEnable <= 1'b1;
		mem(32'h00400000, 3'b100);
		mem(32'h007FFFFC, 3'b010);
		mem(32'h00800000, 3'b000);
		mem(32'h00040010, 3'b000);
		cfgw(8'h30, 32'h00040001);
		cfgr(8'h30, 32'h00040001);
		mem(32'h0007FFF0, 3'b001);
		mem(32'h00080000, 3'b000);
		@(posedge core_clk);
		pciMemEnable <= 1'b0;
		mem(32'h0007FFF0, 3'b000);
		$display("test config done");
	endtask
	task automatic t_setup;
		iow(16'h46E8, 8'h18);
		cyc(2);
		chk("vgaEnable", 0, vgaEnable_q);
		@(posedge core_clk);
		vlBusPin <= 1'b1;
		boardStrapPin <= 1'b1;
		cyc(4);
		iow(16'h46E8, 8'h18);
		iow(16'h0102, 8'h01);
		cyc(2);
		chk("vgaEnable", 1, vgaEnable_q);
		chk("vgaAwake", 1, vgaAwake_q);
		ior(16'h0102, 8'h01);
		iow(16'h0106, 8'h02);
		cyc(2);
		chk("vgaAwake", 0, vgaAwake_q);
		ior(16'h0106, 8'h02);
		@(posedge core_clk);
		boardStrapPin <= 1'b0;
		cyc(4);
		iow(16'h0106, 8'h03);
		ior(16'h0106, 8'h00);
		@(posedge core_clk);
		boardStrapPin <= 1'b1;
		cyc(4);
		ior(16'h0106, 8'h02);
		iow(16'h0106, 8'h00);
		iow(16'h46E8, 8'h08);
		iow(16'h0102, 8'h00);
		ior(16'h0102, 8'h00);
		cyc(2);
		chk("vgaAwake", 1, vgaAwake_q);
		$display("test setup done");
	endtask
	task automatic t_misc;
		int i;
		// Legacy memory cycle held so the grant can be judged
		@(posedge core_clk);
		memReq <= '{valid: 1'b1, legacy: 1'b1, addr: 32'h000A0000};
		for (i = 0; i < 4; i++) begin
			iow(16'h03C2, 8'hF3 | 8'(i << 2));
			ior(16'h03CC, 8'hE3 | 8'(i << 2));
			chk("dotClkSel", i, dotClkSel_q);
			chk("color", 1, ioColor_q);
			chk("pageLow", 1, pageLow_q);
			chk("grant", 1, legacyGrant_q);
		end
		iow(16'h03C2, 8'h00);
		cyc(2);
		chk("pins", 3'b000, {ioColor_q, pageLow_q, legacyGrant_q});
		@(posedge core_clk);
		memReq <= '0;
		iow(16'h03DA, 8'h08);
		ior(16'h03CA, 8'h00);
		iow(16'h03BA, 8'h0F);
		ior(16'h03CA, 8'h0B);
		$display("test misc done");
	endtask
	task automatic t_sync;
		iow(16'h03C2, 8'hC1);
		iow(16'h03DA, 8'h08);
		@(posedge core_clk);
		{vsyncRaw, vDispEn, hsyncRaw, hDispEn} <= 4'b0110;
		cyc(3);
		chk("syncPins", 2'b00, {vsyncPin_q, hsyncPin_q});
		iow(16'h03DA, 8'h00);
		cyc(3);
		chk("vsyncPin", 1, vsyncPin_q);
		iow(16'h03C2, 8'h01);
		@(posedge core_clk);
		{vsyncRaw, hDispEn, videoFeedback} <= 4'b1110;
		cyc(3);
		chk("syncPins", 2'b11, {vsyncPin_q, hsyncPin_q});
		ior(16'h03DA, 8'h29);
		ior(16'h03BA, 8'h00);
		iow(16'h03DA, 8'h08);
		@(posedge core_clk);
		{vsyncRaw, hDispEn, emulationModeBit} <= 3'b001;
		{crtIrq, senseIn} <= 2'b11;
		cyc(3);
		ior(16'h03DA, 8'h28);
		ior(16'h03C2, 8'h90);
		@(posedge core_clk);
		crtIrq <= 1'b0;
		cyc(3);
		ior(16'h03C2, 8'h10);
		$display("test sync done");
	endtask
	task automatic t_seq;
		logic [7:0] md [5] = '{8'h01, 8'h05, 8'h11, 8'h15, 8'h00};
		int         ch [5] = '{8, 8, 8, 8, 9};
		int         ld [5] = '{8, 16, 32, 32, 9};
		int         i;
		int         n;
		logic       p;
		iow(16'h03C4, 8'hFF);
		ior(16'h03C4, 8'h07);
		iow(16'h03C4, 8'h00);
		iow(16'h03C5, 8'h00);
		cyc(2);
		chk("rstN", 2'b00, {seqAsyncRstN_q, seqSyncRstN_q});
		iow(16'h03C5, 8'h01);
		cyc(2);
		chk("rstN", 2'b10, {seqAsyncRstN_q, seqSyncRstN_q});
		iow(16'h03C5, 8'h03);
		iow(16'h03C4, 8'h01);
		@(posedge core_clk);
		dotTick <= 1'b1;
		for (i = 0; i < 5; i++) begin
			iow(16'h03C5, md[i]);
			gap(1'b0, n);
			gap(1'b0, n);
			chk("charGap", ch[i], n);
			gap(1'b1, n);
			gap(1'b1, n);
			chk("loadGap", ld[i], n);
		end
		iow(16'h03C5, 8'h09);
		cyc(2);
		p = pixClkEn_q;
		cyc(1);
		chk("pixAlt", !p, pixClkEn_q);
		iow(16'h03C5, 8'h01);
		cyc(2);
		p = pixClkEn_q;
		cyc(1);
		chk("pixOn", 2'b11, {p, pixClkEn_q});
		$display("test sequencer done");
	endtask

	// Main sequence
	initial begin
		{nrst, pciMemEnable, vlBusPin, boardStrapPin, crtIrq} = '0;
		{hDispEn, vDispEn, vsyncRaw, hsyncRaw, emulationModeBit} = '0;
		{senseIn, dotTick, videoFeedback} = '0;
		memReq = '0;
		err_total = 0;
		check_count = 0;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		cyc(2);
		t_reset();
		t_cfg();
		t_setup();
		t_misc();
		t_sync();
		t_seq();
		report_and_stop();
	end
endmodule
